// file: bench/epa_core_model.sv
// Core stand-in for the arbiter: boots, tracks nesting, returns on request.
// Assumes the arbiter handshake is synchronous to clk_sys_i.
`timescale 1ns/1ps
module epa_core_model #(
    parameter int BOOT_LAT = 16
) (
    // Clock and reset
    input  wire logic                   clk_sys_i,
    input  wire logic                   srst_i,
    // Arbiter side
    input  wire epa_pkg::epa_dispatch_t dispatch_i,
    input  wire logic                   tail_chain_i,
    output logic                        first_instr_o,
    output logic                        handler_exit_o,
    // Bench side
    input  wire logic                   ret_req_i,
    input  wire logic [3:0]             ret_lat_i,
    output logic                        booted_o
);
    import epa_pkg::*;
    int boot_cnt;
    int ret_cnt;
    int depth;
    int d;
    ////////////////////////////////////////////////////////////////////////
    // Boot pulse, handler nesting and return delay
    always @(posedge clk_sys_i) begin
        first_instr_o  <= 1'b0;
        handler_exit_o <= 1'b0;
        d = depth;
        if (srst_i) begin
            boot_cnt <= 0;
            ret_cnt  <= 0;
            depth    <= 0;
            booted_o <= 1'b0;
        end else begin
            // First instruction of the reset handler, once
            if (!booted_o) begin
                boot_cnt <= boot_cnt + 1;
                if (boot_cnt == BOOT_LAT) begin
                    first_instr_o <= 1'b1;
                    booted_o      <= 1'b1;
                end
            end
            // Every entry opens a level; a chained one follows the exit
            // that already closed the old level
            if (dispatch_i.take === 1'b1 || tail_chain_i === 1'b1)
                d = d + 1;
            // Return only from a running handler, prompt or slow
            if (ret_req_i && d > 0)
                ret_cnt <= int'(ret_lat_i) + 1;
            else if (ret_cnt > 0) begin
                ret_cnt <= ret_cnt - 1;
                if (ret_cnt == 1) begin
                    handler_exit_o <= 1'b1;
                    d = d - 1;
                end
            end
            depth <= d;
        end
    end
endmodule // epa_core_model

// file: bench/testbench.sv
// Self-checking bench for the exception priority arbiter.
// Assumes one 200 MHz clock and the core model on the handshake side.
`timescale 1ns/1ps
module testbench;
    import epa_pkg::*;
    logic          clk_sys_i, srst_i, reg_wr, reg_rd, halted, ret_req;
    logic [7:0]    reg_addr;
    logic [31:0]   reg_wdata, reg_rdata, rd_v, ctrl_v;
    logic [39:0]   irq;
    logic [5:0]    src;
    logic [3:0]    ret_lat;
    logic          push, fetch, pop, chain, first_instr, hexit, booted;
    epa_dispatch_t dispatch;
    int            mismatches, comparisons, pops, k;
    logic [6:0]    take_q[$];
    logic [3:0]    flag_q[$];
    logic [6:0]    sys_pos[5] = '{POS_MEM, POS_BUS, POS_USAGE, POS_SVC,
                                  POS_TICK};
    ////////////////////////////////////////////////////////////////////////
    // Design and core model
    epa_arbiter dut_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .irq_i(irq),
        .fault_mem_i(src[0]), .fault_bus_i(src[1]), .fault_usage_i(src[2]),
        .svc_i(src[3]), .tick_i(src[4]), .dbg_req_i(src[5]),
        .halted_i(halted), .first_instr_i(first_instr),
        .handler_exit_i(hexit), .dispatch_o(dispatch),
        .stack_push_o(push), .vec_fetch_o(fetch), .stack_pop_o(pop),
        .tail_chain_o(chain));
    epa_core_model core_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .dispatch_i(dispatch), .tail_chain_i(chain),
        .first_instr_o(first_instr), .handler_exit_o(hexit),
        .ret_req_i(ret_req), .ret_lat_i(ret_lat), .booted_o(booted));
    ////////////////////////////////////////////////////////////////////////
    // Clock and dispatch monitor
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        if (dispatch.take === 1'b1) begin
            take_q.push_back(dispatch.pos);
            flag_q.push_back({push, fetch, pop, chain});
        end
        if (pop === 1'b1)
            pops++;
    end
    ////////////////////////////////////////////////////////////////////////
    // Compare, bus and stimulus tasks
    task automatic check(input logic [31:0] seen, exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h want %h", $time, what,
                     seen, exp);
        end
    endtask
    task automatic reg_wr_t(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr    <= 1'b0;
    endtask
    task automatic reg_rd_t(input logic [7:0] a);
        @(posedge clk_sys_i);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd   <= 1'b0;
        #1 rd_v = reg_rdata;
    endtask
    task automatic pulse(input logic [39:0] lines, input logic [5:0] s);
        @(posedge clk_sys_i);
        irq <= lines;
        src <= s;
        @(posedge clk_sys_i);
        irq <= '0;
        src <= '0;
    endtask
    task automatic expect_take(input logic [6:0] pos, input logic [3:0] f);
        int n;
        n = 0;
        while (take_q.size() == 0 && n < 40) begin
            @(posedge clk_sys_i);
            #1 n++;
        end
        check(32'(take_q.size() != 0), 32'h1, "dispatch seen");
        if (take_q.size() != 0) begin
            check(32'(take_q.pop_front()), 32'(pos), "position");
            check(32'(flag_q.pop_front()), 32'(f), "entry flags");
        end
    endtask
    task automatic expect_none(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1 check(32'(take_q.size()), 32'h0, "no dispatch");
    endtask
    task automatic ret_t();
        @(posedge clk_sys_i);
        ret_req <= 1'b1;
        @(posedge clk_sys_i);
        ret_req <= 1'b0;
        repeat (int'(ret_lat) + 6) @(posedge clk_sys_i);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        mismatches++;
        $display("unexpected at %0t: run did not finish", $time);
        stop_test();
    end
    ////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        {srst_i, reg_wr, reg_rd, halted, ret_req} = 5'h10;
        {reg_addr, reg_wdata, irq, src, ret_lat} = '0;
        {mismatches, comparisons, pops} = '0;
        repeat (6) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        // Boot: nothing taken before the first instruction
        reg_wr_t(REG_ENABLE0, 32'h0000_000b);
        pulse(40'h1, 6'h0);
        expect_none(3);
        check(32'(booted), 32'h0, "boot pending");
        expect_take(POS_IRQ0, 4'hc);
        ret_t();
        check(pops, 1, "state restore");
        $display("test boot done");
        // Reset values, field width and an unmapped address
        for (k = 0; k < 40; k++) begin
            reg_rd_t(REG_PRIO0 + 8'(k));
            check(rd_v, 32'h0, "line prio reset");
        end
        reg_rd_t(REG_SYSPRI);
        check(rd_v, 32'h0, "system prio reset");
        reg_wr_t(REG_SYSPRI, 32'hffff_ffff);
        reg_rd_t(REG_SYSPRI);
        check(rd_v, 32'h0777_7777, "system prio fields");
        reg_wr_t(REG_PRIO0 + 8'h05, 32'h0000_0005);
        reg_rd_t(REG_PRIO0 + 8'h05);
        check(rd_v, 32'h5, "prio field");
        reg_wr_t(8'h08, 32'hffff_ffff);
        reg_rd_t(8'h08);
        check(rd_v, 32'h0, "unmapped read");
        $display("test registers done");
        // Equal levels by position, then urgency by value; both chain
        for (k = 0; k < 2; k++) begin
            reg_wr_t(REG_PRIO0, k ? 32'h2 : 32'h1);
            reg_wr_t(REG_PRIO0 + 8'h01, k ? 32'h0 : 32'h1);
            pulse(40'h3, 6'h0);
            expect_take(k ? POS_IRQ0 + 7'h1 : POS_IRQ0, 4'hc);
            ret_t();
            expect_take(k ? POS_IRQ0 : POS_IRQ0 + 7'h1, 4'h5);
            ret_t();
        end
        $display("test ordering done");
        // Disabled and reserved lines are never taken
        pulse(40'h804, 6'h0);
        expect_none(10);
        reg_rd_t(REG_PEND0);
        check(rd_v, 32'h4, "pending lines");
        $display("test refusal done");
        // Grouping, preemption and the non-maskable interrupt
        reg_wr_t(REG_PRIO0, 32'h3);
        reg_wr_t(REG_PRIO0 + 8'h01, 32'h2);
        reg_wr_t(REG_PRIO0 + 8'h03, 32'h3);
        reg_wr_t(REG_GROUP, 32'h1);
        pulse(40'h1, 6'h0);
        expect_take(POS_IRQ0, 4'hc);
        pulse(40'h2, 6'h0);
        expect_none(8);
        reg_wr_t(REG_GROUP, 32'h0);
        expect_take(POS_IRQ0 + 7'h1, 4'hc);
        pulse(40'h8, 6'h0);
        expect_none(8);
        ctrl_v = 32'h0;
        ctrl_v[CTRL_NMI] = 1'b1;
        reg_wr_t(REG_CTRL, ctrl_v);
        expect_take(POS_NMI, 4'hc);
        ret_lat = 4'h9;
        ret_t();
        expect_take(POS_IRQ0 + 7'h3, 4'h5);
        ret_t();
        expect_none(2);
        ret_t();
        $display("test preemption done");
        // System exceptions, escalation and debug monitor
        ctrl_v = 32'h0;
        ctrl_v[CTRL_BUSEN] = 1'b1;
        ctrl_v[CTRL_MEMEN] = 1'b1;
        ctrl_v[CTRL_USEEN] = 1'b1;
        ctrl_v[CTRL_DBGEN] = 1'b1;
        reg_wr_t(REG_CTRL, ctrl_v);
        for (k = 0; k < 5; k++) begin
            pulse(40'h0, 6'(1 << k));
            expect_take(sys_pos[k], 4'hc);
            ret_t();
        end
        ctrl_v[CTRL_PSV] = 1'b1;
        reg_wr_t(REG_CTRL, ctrl_v);
        expect_take(POS_PSV, 4'hc);
        ret_t();
        halted <= 1'b1;
        pulse(40'h0, 6'h20);
        expect_none(8);
        halted <= 1'b0;
        pulse(40'h0, 6'h20);
        expect_take(POS_DBG, 4'hc);
        ret_t();
        ctrl_v = 32'h0;
        reg_wr_t(REG_CTRL, ctrl_v);
        pulse(40'h0, 6'h1);
        expect_take(POS_HARD, 4'hc);
        ret_t();
        $display("test system done");
        stop_test();
    end
endmodule // testbench

// file: verilog/epa_arbiter.sv
// Exception priority arbiter: ranks exceptions and interrupt lines and
// steers entry, return and tail-chain for the core.
// Assumes core handshakes are synchronous to clk_sys_i.
//
// Summary of operation
// - Eight settable levels for seven system exceptions and thirty lines.
// - Settable level zero ranks just below reset, NMI and hard fault.
// - All settable priority fields reset to zero.
// - Equal priority: lower position number wins.
// - Reset, NMI, hard fault fixed at -3, -2, -1 in positions 1-3.
// - After reset's first instruction, activation drops to base level.
// - NMI preempted only by reset; raised only by software write.
// - Blocked or disabled faults escalate to hard fault.
// - Memory, bus, usage faults at 4,5,6; 7-10 and 13 reserved.
// - Bus fault reporting enabled by software; precise or imprecise.
// - Supervisor call 11, tick 15, software-only pendable request 14.
// - Debug monitor only when enabled, not halting, and more urgent.
// - Interrupt lines enter asynchronously at positions 16 and up.
// - Lines 0-10 map to ports, serial, two-wire and motor sources.
// - Lines 14-26, 28-32 and 39 mapped; unlisted lines reserved.
// - Entry stacks state while vector fetch runs in parallel.
// - Pending exception at exit chains directly, no restore.
// - Priority split into preemption and subpriority by software.
// - Stack top loaded from vector entry zero on reset.
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module epa_arbiter #(
    parameter int IRQ_N = epa_pkg::IRQ_N
) (
    // Clock and reset
    input  wire logic                  clk_sys_i,
    input  wire logic                  srst_i,
    // Register port
    input  wire logic [7:0]            reg_addr_i,
    input  wire logic [31:0]           reg_wdata_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    output logic      [31:0]           reg_rdata_o,
    // Sources
    input  wire logic [IRQ_N-1:0]      irq_i,
    input  wire logic                  fault_mem_i,
    input  wire logic                  fault_bus_i,
    input  wire logic                  fault_usage_i,
    input  wire logic                  svc_i,
    input  wire logic                  tick_i,
    input  wire logic                  dbg_req_i,
    input  wire logic                  halted_i,
    // Core handshake
    input  wire logic                  first_instr_i,
    input  wire logic                  handler_exit_i,
    output epa_pkg::epa_dispatch_t     dispatch_o,
    output logic                       stack_push_o,
    output logic                       vec_fetch_o,
    output logic                       stack_pop_o,
    output logic                       tail_chain_o
);
    import epa_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef enum logic [3:0] {
        ST_RESET = 4'h1, ST_RUN = 4'h2, ST_HANDLER = 4'h4, ST_LOADSP = 4'h8
    } epa_state_t;
    epa_state_t             state_reg, state_next;
    logic [IRQ_N-1:0]       en_reg, pend_reg;
    logic [PRIO_W-1:0]      prio_reg [IRQ_N];
    logic [PRIO_W-1:0]      sysp_reg [7];   // mem,bus,usage,svc,dbg,psv,tick
    logic [2:0]             group_reg;
    logic [5:0]             ctrl_reg;
    logic [6:0]             sys_pend_reg;   // same order as sysp_reg
    logic                   hard_pend_reg;
    logic [3:0]             act_rank_reg;   // rank of running handler
    logic [6:0]             act_pos_reg;
    logic [PRIO_W-1:0]      act_prio_reg;   // raw level of running handler
    logic                   base_reg;

    ////////////////////////////////////////////////////////////////////////
    // Write decode
    wire wr_en0   = reg_wr_i && reg_addr_i == REG_ENABLE0;
    wire wr_en1   = reg_wr_i && reg_addr_i == REG_ENABLE1;
    wire wr_ctrl  = reg_wr_i && reg_addr_i == REG_CTRL;
    wire wr_sysp  = reg_wr_i && reg_addr_i == REG_SYSPRI;
    wire wr_group = reg_wr_i && reg_addr_i == REG_GROUP;
    wire [7:0] prio_idx = reg_addr_i - REG_PRIO0;
    wire wr_prio  = reg_wr_i && reg_addr_i >= REG_PRIO0
                    && prio_idx < 8'(IRQ_N);

    ////////////////////////////////////////////////////////////////////////
    // Rank function: preemption part only, lower is more urgent
    function automatic logic [3:0] pre_rank(input logic [2:0] p,
                                            input logic [2:0] g);
        logic [2:0] m;
        m = 3'h7 << g;
        return RANK_SET0 + {1'b0, p & m};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Full-key selection: {rank, subprio, position}, lowest wins
    logic [13:0] best_key;
    logic        best_vld;
    logic [3:0]  best_rank;
    always_comb begin
        logic [13:0] k;
        k = 14'h0;
        best_key = 14'h3fff;
        best_vld = 1'b0;
        for (int i = 0; i < 7; i++) begin
            k = {pre_rank(sysp_reg[i], group_reg), sysp_reg[i],
                 (i < 3) ? POS_MEM + 7'(i) : POS_SVC + 7'(i - 3)};
            if (i == 5)
                k[6:0] = POS_PSV;
            if (i == 6)
                k[6:0] = POS_TICK;
            if (sys_pend_reg[i] && k < best_key) begin
                best_key = k;
                best_vld = 1'b1;
            end
        end
        for (int i = 0; i < IRQ_N; i++) begin
            k = {pre_rank(prio_reg[i], group_reg), prio_reg[i],
                 POS_IRQ0 + 7'(i)};
            if (pend_reg[i] && en_reg[i] && IRQ_IMPL[i]
                && k < best_key) begin
                best_key = k;
                best_vld = 1'b1;
            end
        end
        if (hard_pend_reg) begin
            best_key = {RANK_HARD, 3'h0, POS_HARD};
            best_vld = 1'b1;
        end
        if (ctrl_reg[CTRL_NMI]) begin
            best_key = {RANK_NMI, 3'h0, POS_NMI};
            best_vld = 1'b1;
        end
        best_rank = best_key[13:10];
    end
    // Running handler's rank under the grouping now in force
    wire [3:0] act_rank =
        (act_rank_reg >= RANK_SET0 && act_rank_reg != RANK_IDLE)
        ? pre_rank(act_prio_reg, group_reg) : act_rank_reg;
    // Preempt only on strictly more urgent preemption rank
    wire take_now = best_vld && best_rank < act_rank;

    // Fault escalation: disabled or too low for current activation
    wire [2:0] f_in  = {fault_usage_i, fault_bus_i, fault_mem_i};
    wire [2:0] f_en  = {ctrl_reg[CTRL_USEEN], ctrl_reg[CTRL_BUSEN],
                        ctrl_reg[CTRL_MEMEN]};
    wire [2:0] f_blk;
    for (genvar g = 0; g < 3; g++) begin : g_esc
        assign f_blk[g] = f_in[g] && (!f_en[g] ||
            pre_rank(sysp_reg[g], group_reg) >= act_rank);
    end
    wire escalate = |f_blk;
    wire dbg_ok = dbg_req_i && ctrl_reg[CTRL_DBGEN] && !halted_i
                  && pre_rank(sysp_reg[4], group_reg) < act_rank;
    wire taken_pos_irq = best_key[6:0] >= POS_IRQ0;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RESET:   state_next = ST_LOADSP;
            ST_LOADSP:  state_next = first_instr_i ? ST_RUN : ST_LOADSP;
            ST_RUN:     state_next = take_now ? ST_HANDLER : ST_RUN;
            ST_HANDLER: state_next = (handler_exit_i && !best_vld)
                                     ? ST_RUN : ST_HANDLER;
            default:    state_next = ST_RESET;
        endcase
    end
    // A stray exit while running must not swallow an entry
    wire entry = take_now && (state_reg == ST_RUN ||
                 (state_reg == ST_HANDLER && !handler_exit_i));
    wire chain = state_reg == ST_HANDLER && handler_exit_i && best_vld;

    ////////////////////////////////////////////////////////////////////////
    // Control and pending registers
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_reg     <= ST_RESET;
            en_reg        <= '0;
            pend_reg      <= '0;
            group_reg     <= 3'h0;
            ctrl_reg      <= 6'h0;
            sys_pend_reg  <= 7'h0;
            hard_pend_reg <= 1'b0;
            act_rank_reg  <= RANK_RESET;
            act_pos_reg   <= POS_RESET;
            act_prio_reg  <= PRIO_RST;
            base_reg      <= 1'b0;
            for (int i = 0; i < IRQ_N; i++)
                prio_reg[i] <= PRIO_RST;
            for (int i = 0; i < 7; i++)
                sysp_reg[i] <= PRIO_RST;
        end else begin
            state_reg <= state_next;
            if (wr_en0)
                en_reg[31:0] <= reg_wdata_i;
            if (wr_en1)
                en_reg[IRQ_N-1:32] <= reg_wdata_i[IRQ_N-33:0];
            if (wr_group)
                group_reg <= reg_wdata_i[2:0];
            if (wr_prio)
                prio_reg[prio_idx[5:0]] <= reg_wdata_i[2:0];
            if (wr_sysp)
                for (int i = 0; i < 7; i++)
                    sysp_reg[i] <= reg_wdata_i[4*i +: 3];
            // Software bits; a write loads all six, NMI included; only the pendable request's pend is set-only
            if (wr_ctrl)
                ctrl_reg <= reg_wdata_i[5:0];
            // Line and system pend: set wins over the clear on take
            for (int i = 0; i < IRQ_N; i++)
                if (irq_i[i] && IRQ_IMPL[i])
                    pend_reg[i] <= 1'b1;
                else if ((entry || chain) && taken_pos_irq
                         && best_key[6:0] == POS_IRQ0 + 7'(i))
                    pend_reg[i] <= 1'b0;
            for (int i = 0; i < 7; i++) begin
                if ((entry || chain) && !taken_pos_irq
                    && best_key[9:7] == sysp_reg[i])
                    sys_pend_reg[i] <= sys_pend_reg[i] &&
                        !(best_key[6:0] == ((i < 3) ? POS_MEM + 7'(i) :
                          (i == 3) ? POS_SVC : (i == 4) ? POS_DBG :
                          (i == 5) ? POS_PSV : POS_TICK));
            end
            for (int g = 0; g < 3; g++)
                if (f_in[g] && !f_blk[g])
                    sys_pend_reg[g] <= 1'b1;
            if (svc_i)
                sys_pend_reg[3] <= 1'b1;
            if (dbg_ok)
                sys_pend_reg[4] <= 1'b1;
            if (wr_ctrl && reg_wdata_i[CTRL_PSV])
                sys_pend_reg[5] <= 1'b1;
            if (tick_i)
                sys_pend_reg[6] <= 1'b1;
            if (escalate)
                hard_pend_reg <= 1'b1;
            else if ((entry || chain) && best_key[6:0] == POS_HARD)
                hard_pend_reg <= 1'b0;
            if ((entry || chain) && best_key[6:0] == POS_NMI
                && !(wr_ctrl && reg_wdata_i[CTRL_NMI]))
                ctrl_reg[CTRL_NMI] <= 1'b0;
            // Activation tracking
            if (state_reg == ST_LOADSP && first_instr_i) begin
                act_rank_reg <= RANK_IDLE;
                act_pos_reg  <= POS_STACK;
                base_reg     <= 1'b1;
            end else if (entry || chain) begin
                act_rank_reg <= best_rank;
                act_pos_reg  <= best_key[6:0];
                act_prio_reg <= best_key[9:7];
            end else if (state_reg == ST_HANDLER && handler_exit_i) begin
                act_rank_reg <= RANK_IDLE;
                act_pos_reg  <= POS_STACK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core outputs and read data
    wire [31:0] rd_mux =
        (reg_addr_i == REG_ENABLE0) ? en_reg[31:0] :
        (reg_addr_i == REG_ENABLE1) ? 32'(en_reg[IRQ_N-1:32]) :
        (reg_addr_i == REG_PEND0)   ? pend_reg[31:0] :
        (reg_addr_i == REG_PEND1)   ? 32'(pend_reg[IRQ_N-1:32]) :
        (reg_addr_i == REG_CTRL)    ? {26'h0, ctrl_reg} :
        (reg_addr_i == REG_SYSPRI)  ? {4'h0, 1'b0, sysp_reg[6],
                                       1'b0, sysp_reg[5], 1'b0, sysp_reg[4],
                                       1'b0, sysp_reg[3], 1'b0, sysp_reg[2],
                                       1'b0, sysp_reg[1], 1'b0, sysp_reg[0]} :
        (reg_addr_i == REG_STATUS)  ? {16'h0, base_reg, act_pos_reg,
                                       state_reg, act_rank_reg} :
        (reg_addr_i == REG_GROUP)   ? {29'h0, group_reg} :
        wr_prio ? 32'h0 :
        (reg_addr_i >= REG_PRIO0 && prio_idx < 8'(IRQ_N))
                                    ? {29'h0, prio_reg[prio_idx[5:0]]} :
        32'h0;
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            reg_rdata_o  <= 32'h0;
            dispatch_o   <= '0;
            stack_push_o <= 1'b0;
            vec_fetch_o  <= 1'b0;
            stack_pop_o  <= 1'b0;
            tail_chain_o <= 1'b0;
        end else begin
            reg_rdata_o  <= reg_rd_i ? rd_mux : 32'h0;
            dispatch_o   <= '{take: entry || chain, pos: best_key[6:0]};
            stack_push_o <= entry;
            vec_fetch_o  <= entry || chain;
            stack_pop_o  <= state_reg == ST_HANDLER && handler_exit_i
                            && !best_vld;
            tail_chain_o <= chain;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_entry;
        entry;
    endsequence
    a_push_fetch: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        s_entry |=> stack_push_o && vec_fetch_o)
        else $error("entry without push and fetch");
    a_chain_nopop: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        chain |=> tail_chain_o && !stack_pop_o && !stack_push_o)
        else $error("tail chain restored state");
    a_nmi_wins: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ctrl_reg[CTRL_NMI] && act_rank > RANK_NMI
        && (state_reg == ST_RUN || state_reg == ST_HANDLER)
        |=> dispatch_o.take && dispatch_o.pos == POS_NMI)
        else $error("nmi not most urgent");
    a_base_level: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        state_reg == ST_LOADSP && first_instr_i |=> act_rank_reg == RANK_IDLE)
        else $error("no drop to base level");
    a_escalate: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        escalate |=> hard_pend_reg || act_pos_reg == POS_HARD)
        else $error("blocked fault not escalated");
    a_prio_reset: assert property (@(posedge clk_sys_i)
        $past(srst_i) |-> prio_reg[0] == PRIO_RST && sysp_reg[0] == PRIO_RST)
        else $error("priority not zero after reset");
    a_dispatch_pos: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        dispatch_o.take |-> dispatch_o.pos != POS_STACK)
        else $error("dispatch of position zero");
    a_disabled_line: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        best_vld && taken_pos_irq |->
            en_reg[best_key[5:0] - 6'h10])
        else $error("disabled line selected");
endmodule // epa_arbiter

// file: verilog/epa_pkg.sv
// Package for the exception priority arbiter: positions, widths, offsets.
// Assumes a single system clock and synchronous active-high reset.
package epa_pkg;
    // Priority field width and reset value
    localparam int          PRIO_W      = 3;
    localparam logic [2:0]  PRIO_RST    = 3'h0;
    // Interrupt line count (bits 0..39 of the interrupt registers)
    localparam int          IRQ_N       = 40;
    // Exception positions
    localparam logic [6:0]  POS_STACK   = 7'h00;
    localparam logic [6:0]  POS_RESET   = 7'h01;
    localparam logic [6:0]  POS_NMI     = 7'h02;
    localparam logic [6:0]  POS_HARD    = 7'h03;
    localparam logic [6:0]  POS_MEM     = 7'h04;
    localparam logic [6:0]  POS_BUS     = 7'h05;
    localparam logic [6:0]  POS_USAGE   = 7'h06;
    localparam logic [6:0]  POS_SVC     = 7'h0b;
    localparam logic [6:0]  POS_DBG     = 7'h0c;
    localparam logic [6:0]  POS_PSV     = 7'h0e;
    localparam logic [6:0]  POS_TICK    = 7'h0f;
    localparam logic [6:0]  POS_IRQ0    = 7'h10;
    // Implemented interrupt lines; unlisted lines are reserved
    localparam logic [39:0] IRQ_IMPL    = 40'h81_f7ff_c7ff;
    // Urgency rank: 4 bits, fixed ones below settable ones
    localparam logic [3:0]  RANK_RESET  = 4'h0;
    localparam logic [3:0]  RANK_NMI    = 4'h1;
    localparam logic [3:0]  RANK_HARD   = 4'h2;
    localparam logic [3:0]  RANK_SET0   = 4'h3;
    localparam logic [3:0]  RANK_IDLE   = 4'hf;
    // Register offsets (word index on the plain port)
    localparam logic [7:0]  REG_ENABLE0 = 8'h00;
    localparam logic [7:0]  REG_ENABLE1 = 8'h01;
    localparam logic [7:0]  REG_PEND0   = 8'h02;
    localparam logic [7:0]  REG_PEND1   = 8'h03;
    localparam logic [7:0]  REG_CTRL    = 8'h04;
    localparam logic [7:0]  REG_STATUS  = 8'h05;
    localparam logic [7:0]  REG_SYSPRI  = 8'h06;
    localparam logic [7:0]  REG_GROUP   = 8'h07;
    localparam logic [7:0]  REG_PRIO0   = 8'h10;
    // Control bits
    localparam int          CTRL_NMI    = 0;
    localparam int          CTRL_PSV    = 1;
    localparam int          CTRL_BUSEN  = 2;
    localparam int          CTRL_MEMEN  = 3;
    localparam int          CTRL_USEEN  = 4;
    localparam int          CTRL_DBGEN  = 5;
    // Core handshake flags
    typedef struct packed {
        logic       take;
        logic [6:0] pos;
    } epa_dispatch_t;
endpackage
